// File: src/interval_timer_pkg.sv
// Shared constants for the three channel interval timer.
// Assumes a 16-bit I/O address bus and byte-wide data.
package interval_timer_pkg;

  // Direct-mapped I/O addresses
  localparam logic [15:0] ADDR_CH0_COUNT = 16'h0040;
  localparam logic [15:0] ADDR_CH1_COUNT = 16'h0041;
  localparam logic [15:0] ADDR_CH2_COUNT = 16'h0042;
  localparam logic [15:0] ADDR_MODE_CTRL = 16'h0043;
  localparam logic [15:0] ADDR_SYS_CTRL = 16'h0061;

  // Control word fields
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_ACC_HI = 5;
  localparam int CW_ACC_LO = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD_BIT = 0;
  localparam logic [1:0] SEL_READ_BACK = 2'h3;

  // Count access formats
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LSB = 2'h1;
  localparam logic [1:0] ACC_MSB = 2'h2;
  localparam logic [1:0] ACC_WORD = 2'h3;

  // Counting modes
  localparam logic [2:0] MODE_TERMINAL = 3'h0;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h1;
  localparam logic [2:0] MODE_RATE = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;

  // System control port bits
  localparam int SCP_GATE2_BIT = 0;
  localparam int SCP_SPK_EN_BIT = 1;
  localparam int SCP_REF_SRC_BIT = 4;
  localparam int SCP_OUT2_BIT = 5;

  // Timer clock from the core clock: low-speed PLL stand-in divided by 31
  localparam int TIMER_DIV = 31;
  localparam logic [4:0] TIMER_DIV_LAST = 5'(TIMER_DIV - 1);

  // Reset values
  localparam logic [7:0] SCP_RESET = 8'h00;
  localparam logic [2:0] MODE_RESET = MODE_TERMINAL;
  localparam logic [1:0] ACC_RESET = ACC_WORD;

endpackage

// File: src/three_channel_interval_timer.sv
// Three channel 16-bit interval timer with its system control port.
// Assumes a byte-wide I/O strobe bus on clk_in and a timer clock either
// divided from clk_in or taken from an external pin.
// Function
// - Three independent 16-bit down counters, each with own mode and count.
// - Channel 0 output drives the timer interrupt line, fixed wiring.
// - Channel 1 is the refresh rate generator; refresh source readable at 0061h.
// - Channel 2 is general; gated by speaker data enable onto speaker pin.
// - Channels 0 and 1 take modes 0, 2, 3, 4; channel 2 all six.
// - Control word written at 0043h selects a channel's mode.
// - Mode 0: output low on load, decrement each timer clock while gate high.
// - Mode 0: gate low holds the count; resume after gate high again.
// - Mode 0: output high at zero until new count or mode 0 word.
// - Mode 1: gate rise starts low pulse; high at zero until next trigger.
// - Mode 1: gate rise during pulse reloads count, extending the pulse.
// - Mode 2: divide by N; one-clock low at count one, then reload.
// - Mode 3: output starts high, count steps by two, toggles at zero.
// - Mode 3 odd N: high (N+1)/2 clocks, low (N-1)/2 clocks.
// - Mode 4: start one clock after load; one-clock strobe after N+1 clocks.
// - Mode 5: load after gate rise; low strobe N+1 clocks after trigger.
// - 32 kHz refresh by default; suspend with refresh_in_suspend_in set forces 32 kHz while channel 1 chosen.
// - Port bit 0 gates channel 2, bit 5 reads its output, bit 1 routes speaker.
// - A new count never changes the programmed mode.
// - Timer clock is PLL divided by 31, or the external pin when selected.
// - Each channel counts binary or BCD as its control word selects.
module three_channel_interval_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // I/O register port
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  // Timer clock selection and external clock pin
  input wire logic ext_clk_sel_in,
  input wire logic ext_timer_clk_in,
  // Refresh source control and 32 kHz pin
  input wire logic refresh_timer_sel_in,
  input wire logic suspend_in,
  input wire logic refresh_in_suspend_in,
  input wire logic clk_32k_in,
  // Outputs to interrupt controller, refresh logic and speaker pin
  output logic timer_interrupt_line_out,
  output logic refresh_clk_out,
  output logic speaker_out
);
  import interval_timer_pkg::*;

  typedef struct packed {
    logic [2:0][15:0] count;
    logic [2:0][15:0] reload;
    logic [2:0][2:0] mode;
    logic [2:0][1:0] acc;
    logic [2:0] bcd;
    logic [2:0] out;
    logic [2:0] armed;
    logic [2:0] pending;
    logic [2:0] run;
    logic [2:0] trig;
    logic [2:0] gate_q;
    logic [2:0] wr_msb;
    logic [2:0] rd_msb;
    logic [2:0][7:0] lsb_hold;
    logic [7:0] scp;
    logic [4:0] div;
    logic [2:0] ext_sync;
    logic ext_level;
    logic [2:0] k32_sync;
    logic k32_level;
    logic [7:0] rdata;
    logic irq;
    logic refresh;
    logic speaker;
  } state_s;

  state_s st;
  state_s next_st;

  // One step down in binary or BCD; zero wraps to the largest count
  function automatic logic [15:0] dec_one(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (v[d*4 +: 4] == 4'h0) begin
            r[d*4 +: 4] = 4'h9;
          end else begin
            r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // Mode field of a control word, with the don't-care top bit folded
  function automatic logic [2:0] cw_mode(input logic [7:0] cw);
    logic [2:0] m;
    m = cw[CW_MODE_HI:CW_MODE_LO];
    if (m[1]) begin
      m = {1'b0, m[1:0]};
    end
    return m;
  endfunction

  // Channel index addressed by a count port, 3 when none
  function automatic logic [1:0] count_port(input logic [15:0] a);
    logic [1:0] c;
    if (a == ADDR_CH0_COUNT) begin
      c = 2'h0;
    end else if (a == ADDR_CH1_COUNT) begin
      c = 2'h1;
    end else if (a == ADDR_CH2_COUNT) begin
      c = 2'h2;
    end else begin
      c = 2'h3;
    end
    return c;
  endfunction

  logic tick;
  logic [2:0] gate;
  logic [15:0] nxt;
  logic [15:0] step;
  logic [1:0] wch;
  logic [1:0] rch;
  logic [2:0] wmode;
  logic ref_timer;
  // Next-state logic for the whole block
  always_comb begin
    next_st = st;
    tick = 1'b0;
    nxt = 16'h0000;
    step = 16'h0000;
    wch = count_port(io_addr_in);
    rch = count_port(io_addr_in);
    wmode = cw_mode(io_wdata_in);
    // Pin synchronisers; a change counts once stages two and three agree
    next_st.ext_sync = {st.ext_sync[1:0], ext_timer_clk_in};
    next_st.k32_sync = {st.k32_sync[1:0], clk_32k_in};
    if (st.ext_sync[1] == st.ext_sync[2]) begin
      next_st.ext_level = st.ext_sync[2];
    end
    if (st.k32_sync[1] == st.k32_sync[2]) begin
      next_st.k32_level = st.k32_sync[2];
    end
    // Common timer clock: divider or filtered external rising edge
    if (st.div == TIMER_DIV_LAST) begin
      next_st.div = 5'h00;
    end else begin
      next_st.div = st.div + 5'h01;
    end
    if (ext_clk_sel_in) begin
      tick = next_st.ext_level && !st.ext_level;
    end else begin
      tick = (st.div == TIMER_DIV_LAST);
    end
    // Gates: channels 0 and 1 always enabled, channel 2 from the port
    gate = {st.scp[SCP_GATE2_BIT], 2'b11};
    // Per-channel counting on the timer clock
    for (int c = 0; c < 3; c++) begin
      next_st.gate_q[c] = gate[c];
      if (gate[c] && !st.gate_q[c]) begin
        next_st.trig[c] = 1'b1;
      end
      if (tick) begin
        next_st.trig[c] = (gate[c] && !st.gate_q[c]) || (st.trig[c] && st.pending[c]);
        nxt = dec_one(st.count[c], st.bcd[c]);
        if (st.pending[c]) begin
          next_st.pending[c] = 1'b0;
          next_st.armed[c] = 1'b1;
          next_st.run[c] = 1'b0;
          if (st.mode[c] != MODE_ONE_SHOT && st.mode[c] != MODE_HW_STROBE) begin
            next_st.count[c] = st.reload[c];
          end
        end else if (st.armed[c]) begin
          case (st.mode[c])
            MODE_TERMINAL: begin
              if (gate[c]) begin
                next_st.count[c] = nxt;
                if (nxt == 16'h0000) begin
                  next_st.out[c] = 1'b1;
                end
              end
            end
            MODE_ONE_SHOT: begin
              if (st.trig[c]) begin
                next_st.count[c] = st.reload[c];
                next_st.out[c] = 1'b0;
                next_st.run[c] = 1'b1;
              end else if (st.run[c]) begin
                next_st.count[c] = nxt;
                if (nxt == 16'h0000) begin
                  next_st.out[c] = 1'b1;
                  next_st.run[c] = 1'b0;
                end
              end
            end
            MODE_RATE: begin
              if (!gate[c]) begin
                next_st.out[c] = 1'b1;
              end else if (st.trig[c]) begin
                next_st.count[c] = st.reload[c];
                next_st.out[c] = 1'b1;
              end else if (st.count[c] == 16'h0001) begin
                next_st.count[c] = st.reload[c];
                next_st.out[c] = 1'b1;
              end else begin
                next_st.count[c] = nxt;
                next_st.out[c] = (nxt != 16'h0001);
              end
            end
            MODE_SQUARE: begin
              step = st.count[c][0] ? 16'h0001 : 16'h0002;
              if (!gate[c]) begin
                next_st.out[c] = 1'b1;
              end else if (st.trig[c]) begin
                next_st.count[c] = st.reload[c];
                next_st.out[c] = 1'b1;
              end else if (st.count[c] == step) begin
                next_st.out[c] = !st.out[c];
                if (st.out[c] && st.reload[c][0]) begin
                  next_st.count[c] = dec_one(st.reload[c], st.bcd[c]);
                end else begin
                  next_st.count[c] = st.reload[c];
                end
              end else if (step == 16'h0001) begin
                next_st.count[c] = nxt;
              end else begin
                next_st.count[c] = dec_one(nxt, st.bcd[c]);
              end
            end
            MODE_SW_STROBE: begin
              if (gate[c]) begin
                next_st.count[c] = nxt;
              end
              next_st.out[c] = !(gate[c] && nxt == 16'h0000 && !st.run[c]);
              if (gate[c] && nxt == 16'h0000) begin
                next_st.run[c] = 1'b1;
              end
            end
            default: begin
              next_st.out[c] = 1'b1;
              if (st.trig[c]) begin
                next_st.count[c] = st.reload[c];
                next_st.run[c] = 1'b1;
              end else if (st.run[c]) begin
                next_st.count[c] = nxt;
                if (nxt == 16'h0000) begin
                  next_st.out[c] = 1'b0;
                  next_st.run[c] = 1'b0;
                end
              end
            end
          endcase
        end
      end
    end
    // Register writes
    if (io_wr_in) begin
      if (io_addr_in == ADDR_MODE_CTRL) begin
        for (int c = 0; c < 3; c++) begin
          if (io_wdata_in[CW_SEL_HI:CW_SEL_LO] == 2'(c)
              && io_wdata_in[CW_ACC_HI:CW_ACC_LO] != ACC_LATCH
              && (c == 2 || (wmode != MODE_ONE_SHOT && wmode != MODE_HW_STROBE))) begin
            next_st.mode[c] = wmode;
            next_st.acc[c] = io_wdata_in[CW_ACC_HI:CW_ACC_LO];
            next_st.bcd[c] = io_wdata_in[CW_BCD_BIT];
            next_st.out[c] = (wmode != MODE_TERMINAL);
            next_st.armed[c] = 1'b0;
            next_st.pending[c] = 1'b0;
            next_st.run[c] = 1'b0;
            next_st.wr_msb[c] = 1'b0;
            next_st.rd_msb[c] = 1'b0;
          end
        end
      end else if (io_addr_in == ADDR_SYS_CTRL) begin
        next_st.scp[SCP_GATE2_BIT] = io_wdata_in[SCP_GATE2_BIT];
        next_st.scp[SCP_SPK_EN_BIT] = io_wdata_in[SCP_SPK_EN_BIT];
      end else if (wch != 2'h3) begin
        // Count bytes in the format that the control word fixed
        case (st.acc[wch])
          ACC_LSB: begin
            next_st.reload[wch] = {8'h00, io_wdata_in};
            next_st.pending[wch] = 1'b1;
          end
          ACC_MSB: begin
            next_st.reload[wch] = {io_wdata_in, 8'h00};
            next_st.pending[wch] = 1'b1;
          end
          default: begin
            if (!st.wr_msb[wch]) begin
              next_st.lsb_hold[wch] = io_wdata_in;
              next_st.wr_msb[wch] = 1'b1;
            end else begin
              next_st.reload[wch] = {io_wdata_in, st.lsb_hold[wch]};
              next_st.pending[wch] = 1'b1;
              next_st.wr_msb[wch] = 1'b0;
            end
          end
        endcase
        // Mode is untouched; running 2 and 3 pick up the count at reload
        if (st.armed[wch] && (st.mode[wch] == MODE_RATE || st.mode[wch] == MODE_SQUARE)) begin
          next_st.pending[wch] = 1'b0;
        end
        if (st.mode[wch] == MODE_TERMINAL) begin
          next_st.out[wch] = 1'b0;
          next_st.armed[wch] = 1'b0;
        end
      end
    end
    // Refresh source: 32 kHz unless channel 1 chosen and not suspended with refresh_in_suspend_in set
    ref_timer = refresh_timer_sel_in && !(suspend_in && refresh_in_suspend_in);
    next_st.scp[SCP_REF_SRC_BIT] = ref_timer;
    next_st.scp[SCP_OUT2_BIT] = next_st.out[2];
    // Register reads; count reads are simple reads of the live count
    if (io_rd_in) begin
      if (io_addr_in == ADDR_SYS_CTRL) begin
        next_st.rdata = st.scp;
      end else if (rch != 2'h3) begin
        case (st.acc[rch])
          ACC_LSB: next_st.rdata = st.count[rch][7:0];
          ACC_MSB: next_st.rdata = st.count[rch][15:8];
          default: begin
            next_st.rdata = st.rd_msb[rch] ? st.count[rch][15:8] : st.count[rch][7:0];
            next_st.rd_msb[rch] = !st.rd_msb[rch];
          end
        endcase
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    // Registered outputs
    next_st.irq = next_st.out[0];
    next_st.refresh = ref_timer ? next_st.out[1] : next_st.k32_level;
    next_st.speaker = next_st.out[2] && next_st.scp[SCP_SPK_EN_BIT];
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      for (int c = 0; c < 3; c++) begin
        st.mode[c] <= MODE_RESET;
        st.acc[c] <= ACC_RESET;
      end
      st.scp <= SCP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign io_rdata_out = st.rdata;
  assign timer_interrupt_line_out = st.irq;
  assign refresh_clk_out = st.refresh;
  assign speaker_out = st.speaker;

endmodule

// File: tb/timer_port_asserts.sv
// Port checker for the three channel interval timer.
// Assumes it is bound to the timer top and sees only its ports.
module timer_port_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [15:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_rdata_out,
  // Refresh, interrupt and speaker
  input wire logic refresh_timer_sel_in,
  input wire logic suspend_in,
  input wire logic refresh_in_suspend_in,
  input wire logic clk_32k_in,
  input wire logic refresh_clk_out,
  input wire logic timer_interrupt_line_out,
  input wire logic speaker_out
);
  import interval_timer_pkg::*;
  logic spk_en;
  logic rd_port;
  logic rd_quiet;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Speaker enable as last written to the control port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      spk_en <= 1'b0;
    end else if (io_wr_in && io_addr_in == ADDR_SYS_CTRL) begin
      spk_en <= io_wdata_in[SCP_SPK_EN_BIT];
    end
  end
  // Read decodes
  assign rd_port = io_rd_in && io_addr_in == ADDR_SYS_CTRL;
  assign rd_quiet = io_rd_in && !(io_addr_in inside {ADDR_CH0_COUNT, ADDR_CH1_COUNT,
    ADDR_CH2_COUNT, ADDR_SYS_CTRL});
  property p_rd_zero;
    rd_quiet |=> io_rdata_out == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("empty read not zero");
  property p_rd_hold;
    !io_rd_in |=> $stable(io_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_port_zero;
    rd_port |=> (io_rdata_out & 8'hCC) == 8'h00;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("port spare bits set");
  property p_spk_gate;
    !spk_en && !$past(spk_en) && !$past(spk_en, 2) |-> !speaker_out;
  endproperty
  a_spk_gate: assert property (p_spk_gate) else $error("speaker not gated");
  property p_ref_32k_hi;
    (!refresh_timer_sel_in && clk_32k_in) [*8] |-> refresh_clk_out;
  endproperty
  a_ref_32k_hi: assert property (p_ref_32k_hi) else $error("refresh not slow clock");
  property p_ref_susp_lo;
    (suspend_in && refresh_in_suspend_in && !clk_32k_in) [*8] |-> !refresh_clk_out;
  endproperty
  a_ref_susp_lo: assert property (p_ref_susp_lo) else $error("suspend refresh wrong");
  property p_refsrc;
    rd_port && !refresh_timer_sel_in && !$past(refresh_timer_sel_in, 4)
      |=> !io_rdata_out[SCP_REF_SRC_BIT];
  endproperty
  a_refsrc: assert property (p_refsrc) else $error("refresh source bit wrong");
  sequence s_spk_steady;
    (spk_en && $stable(speaker_out)) [*3];
  endsequence
  property p_out2;
    s_spk_steady ##0 rd_port ##1 $stable(speaker_out) |-> io_rdata_out[SCP_OUT2_BIT] == speaker_out;
  endproperty
  a_out2: assert property (p_out2) else $error("channel 2 bit wrong");
  c_irq: cover property ($rose(timer_interrupt_line_out));
  c_spk: cover property ($fell(speaker_out));
  c_port: cover property (rd_port);
endmodule

bind three_channel_interval_timer timer_port_checker chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
  .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out),
  .refresh_timer_sel_in(refresh_timer_sel_in), .suspend_in(suspend_in),
  .refresh_in_suspend_in(refresh_in_suspend_in), .clk_32k_in(clk_32k_in),
  .refresh_clk_out(refresh_clk_out), .timer_interrupt_line_out(timer_interrupt_line_out),
  .speaker_out(speaker_out)
);

// File: tb/timer_far_end.sv
// Far side of the timer: slow oscillator, interrupt and refresh sinks.
// Assumes the bench wires it to the timer pins.
module timer_far_end #(
  parameter int HALF_NS = 100
) (
  // Pins seen from the far side
  input wire logic irq_in,
  input wire logic refresh_in,
  output logic osc_32k_out,
  // Event counts
  output int irq_edges_out,
  output int refresh_edges_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free-running slow oscillator, shortened to keep the run brief
  initial osc_32k_out = 1'b0;
  always #(HALF_NS) osc_32k_out = ~osc_32k_out;
  // Interrupt controller and refresh logic count rising edges
  initial irq_edges_out = 0;
  initial refresh_edges_out = 0;
  always @(posedge irq_in) irq_edges_out++;
  always @(posedge refresh_in) refresh_edges_out++;
endmodule

// File: tb/three_channel_interval_timer_test.sv
// Self-checking bench for the three channel interval timer.
// Assumes the timer package, the far-end model and the bound checker.
module three_channel_interval_timer_test;
  timeunit 1ns;
  timeprecision 100ps;
  import interval_timer_pkg::*;
  localparam int TK = TIMER_DIV;
  localparam int EXT_HALF = 38;
  localparam int EXT_HIGH = 3 * EXT_HALF / 2; // Rate 4 on the pin: three ticks high
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] io_addr_in = 16'h0000;
  logic [7:0] io_wdata_in = 8'h00;
  logic io_wr_in = 1'b0;
  logic io_rd_in = 1'b0;
  logic refresh_timer_sel_in = 1'b0;
  logic suspend_in = 1'b0;
  logic refresh_in_suspend_in = 1'b0;
  logic ext_clk_sel_in = 1'b0;
  logic ext_timer_clk_in = 1'b0;
  logic [7:0] io_rdata_out;
  logic clk_32k_in, timer_interrupt_line_out, refresh_clk_out, speaker_out;
  logic [7:0] rd;
  int n_errors = 0;
  int n_tests = 0;
  int irqs, hi, lo, t, n;

  three_channel_interval_timer dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in),
    .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out), .ext_clk_sel_in(ext_clk_sel_in),
    .ext_timer_clk_in(ext_timer_clk_in), .refresh_timer_sel_in(refresh_timer_sel_in),
    .suspend_in(suspend_in), .refresh_in_suspend_in(refresh_in_suspend_in),
    .clk_32k_in(clk_32k_in), .timer_interrupt_line_out(timer_interrupt_line_out),
    .refresh_clk_out(refresh_clk_out), .speaker_out(speaker_out));
  timer_far_end far_u (.irq_in(timer_interrupt_line_out), .refresh_in(refresh_clk_out),
    .osc_32k_out(clk_32k_in), .irq_edges_out(irqs), .refresh_edges_out());

  // Core clock
  always #2 clk_in = ~clk_in;
  // External timer clock pin, offset so no edge meets a core clock edge
  initial begin
    #1;
    forever #(EXT_HALF) ext_timer_clk_in = ~ext_timer_clk_in;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    @(negedge clk_in);
    io_wr_in = 1'b0;
  endtask
  task automatic rdp(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_in);
    io_addr_in = a;
    io_rd_in = 1'b1;
    @(negedge clk_in);
    io_rd_in = 1'b0;
    @(negedge clk_in);
    d = io_rdata_out;
  endtask
  task automatic prog(input logic [1:0] ch, input logic [2:0] m, input logic [15:0] c);
    wr(ADDR_MODE_CTRL, {ch, ACC_WORD, m, 1'b0});
    wr(ADDR_CH0_COUNT + 16'(ch), c[7:0]);
    wr(ADDR_CH0_COUNT + 16'(ch), c[15:8]);
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? timer_interrupt_line_out : s == 1 ? speaker_out : refresh_clk_out;
  endfunction
  task automatic till(input int s, input logic v, output int c);
    c = 0;
    while (sig(s) !== v && c < 5000) begin
      @(negedge clk_in);
      c++;
    end
    if (c == 5000) check("wait", 32'(v), 32'(sig(s)));
  endtask
  // Cycle counts of one high and one low phase
  task automatic pulse(input int s, output int h, output int l);
    int c;
    till(s, 1'b0, c);
    till(s, 1'b1, c);
    till(s, 1'b0, h);
    till(s, 1'b1, l);
  endtask
  function automatic int exp_len(input int m, input int c, input bit high);
    if (m == 2) return high ? (c - 1) * TK : TK;
    return high ? (c + 1) / 2 * TK : c / 2 * TK;
  endfunction
  function automatic logic win(input int w, input int k);
    return w >= k * TK - 2 && w <= (k + 1) * TK + 3;
  endfunction
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    end_of_test();
  end

  // Main sequence
  initial begin
    void'($urandom(57970));
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    rdp(ADDR_SYS_CTRL, rd);
    check("port reset", 8'h00, rd);
    wr(ADDR_SYS_CTRL, 8'hFF);
    rdp(ADDR_SYS_CTRL, rd);
    check("port bits", 8'h03, rd);
    rdp(ADDR_MODE_CTRL, rd);
    check("mode read", 8'h00, rd);
    rdp(16'h0050, rd);
    check("empty read", 8'h00, rd);
    $display("test registers finished");
    n = 2 + $urandom % 8;
    prog(2'h0, MODE_RATE, 16'(n));
    pulse(0, hi, lo);
    check("rate high", exp_len(2, n, 1), hi);
    check("rate low", TK, lo);
    wr(ADDR_MODE_CTRL, 8'h32);
    pulse(0, hi, lo);
    check("refused mode", exp_len(2, n, 1), hi);
    wr(ADDR_CH0_COUNT, 8'h04);
    wr(ADDR_CH0_COUNT, 8'h00);
    pulse(0, hi, lo);
    pulse(0, hi, lo);
    check("new count", exp_len(2, 4, 1), hi);
    check("irq edges", 1, irqs > 3);
    $display("test rate finished");
    for (int k = 0; k < 2; k++) begin
      n = 3 + k + 2 * ($urandom % 4);
      prog(2'h2, MODE_SQUARE, 16'(n));
      pulse(1, hi, lo);
      check("square high", exp_len(3, n, 1), hi);
      check("square low", exp_len(3, n, 0), lo);
      repeat (4) rdp(ADDR_SYS_CTRL, rd);
    end
    $display("test square finished");
    n = 2 + $urandom % 6;
    prog(2'h2, MODE_SW_STROBE, 16'(n));
    till(1, 1'b0, t);
    till(1, 1'b1, lo);
    check("strobe time", 1, win(t, n));
    check("strobe width", TK, lo);
    wr(ADDR_SYS_CTRL, 8'h02);
    prog(2'h2, MODE_HW_STROBE, 16'(n));
    repeat ((n + 3) * TK) @(negedge clk_in);
    check("no trigger", 1, speaker_out);
    wr(ADDR_SYS_CTRL, 8'h03);
    till(1, 1'b0, t);
    till(1, 1'b1, lo);
    check("trigger time", 1, win(t, n));
    check("trigger width", TK, lo);
    $display("test strobes finished");
    wr(ADDR_SYS_CTRL, 8'h02);
    prog(2'h2, MODE_ONE_SHOT, 16'(n));
    wr(ADDR_SYS_CTRL, 8'h03);
    till(1, 1'b0, t);
    till(1, 1'b1, lo);
    check("one-shot width", n * TK, lo);
    wr(ADDR_SYS_CTRL, 8'h02);
    wr(ADDR_SYS_CTRL, 8'h03);
    till(1, 1'b0, t);
    repeat (2 * TK) @(negedge clk_in);
    wr(ADDR_SYS_CTRL, 8'h02);
    wr(ADDR_SYS_CTRL, 8'h03);
    till(1, 1'b1, lo);
    check("retrigger", 1, lo > n * TK && lo <= (n + 2) * TK);
    $display("test one-shot finished");
    wr(ADDR_SYS_CTRL, 8'h02);
    prog(2'h2, MODE_TERMINAL, 16'(n));
    repeat ((n + 2) * TK) @(negedge clk_in);
    check("gate hold", 1'b0, speaker_out);
    wr(ADDR_SYS_CTRL, 8'h03);
    till(1, 1'b1, t);
    check("terminal time", 1, win(t, n - 1));
    repeat (6 * TK) @(negedge clk_in);
    check("terminal hold", 1, speaker_out);
    $display("test terminal finished");
    refresh_timer_sel_in = 1'b1;
    prog(2'h1, MODE_RATE, 16'h0003);
    pulse(2, hi, lo);
    check("refresh high", exp_len(2, 3, 1), hi);
    rdp(ADDR_SYS_CTRL, rd);
    check("refresh source", 1, rd[SCP_REF_SRC_BIT]);
    suspend_in = 1'b1;
    refresh_in_suspend_in = 1'b1;
    rdp(ADDR_SYS_CTRL, rd);
    check("suspend source", 0, rd[SCP_REF_SRC_BIT]);
    repeat (200) @(negedge clk_in);
    suspend_in = 1'b0;
    refresh_timer_sel_in = 1'b0;
    repeat (200) @(negedge clk_in);
    $display("test refresh finished");
    wr(ADDR_MODE_CTRL, {2'h0, ACC_LSB, MODE_RATE, 1'b1});
    wr(ADDR_CH0_COUNT, 8'h10);
    pulse(0, hi, lo);
    check("bcd high", exp_len(2, 10, 1), hi);
    prog(2'h0, MODE_RATE, 16'hFF23);
    repeat (TK + 2) @(negedge clk_in);
    rdp(ADDR_CH0_COUNT, rd);
    rdp(ADDR_CH0_COUNT, rd);
    check("tick count msb", 8'hFF, rd);
    ext_clk_sel_in = 1'b1;
    prog(2'h0, MODE_RATE, 16'h0004);
    pulse(0, hi, lo);
    check("external tick", 1, hi >= EXT_HIGH - 2 && hi <= EXT_HIGH + 2);
    ext_clk_sel_in = 1'b0;
    $display("test count formats finished");
    end_of_test();
  end
endmodule
